// >>> src/mtp_pkg.sv
// Package for the motion trigger port block: register map, field codes,
// reset values and timing constants.
// Assumes a 40 MHz APB clock and 32-bit APB data.
package mtp_pkg;

  // Register byte offsets
  localparam logic [7:0] MTP_CFG_OFS      = 8'h00;
  localparam logic [7:0] MTP_STATUS_OFS   = 8'h04;
  localparam logic [7:0] MTP_GPO_OFS      = 8'h08;
  localparam logic [7:0] MTP_WIDTH_OFS    = 8'h0c;
  localparam logic [7:0] MTP_START_F_OFS  = 8'h10;
  localparam logic [7:0] MTP_INTVL_F_OFS  = 8'h14;
  localparam logic [7:0] MTP_START_R_OFS  = 8'h18;
  localparam logic [7:0] MTP_INTVL_R_OFS  = 8'h1c;
  localparam logic [7:0] MTP_COUNTS_OFS   = 8'h20;
  localparam logic [7:0] MTP_REL_DIST_OFS = 8'h24;
  localparam logic [7:0] MTP_ABS_POS_OFS  = 8'h28;

  // Config field positions: port n mode at [n*8+3:n*8], polarity at n*8+4
  localparam int MTP_CFG_PORT_STRIDE = 8;
  localparam int MTP_CFG_POL_BIT     = 4;
  // Count register: fwd pulses [7:0], rev pulses [15:8], cycles [23:16]
  localparam int MTP_CNT_FWD_LSB     = 0;
  localparam int MTP_CNT_REV_LSB     = 8;
  localparam int MTP_CNT_CYC_LSB     = 16;
  // Status fields
  localparam int MTP_ST_IN_LSB       = 0;
  localparam int MTP_ST_CLASH_BIT    = 2;
  localparam int MTP_ST_BUSY_BIT     = 3;

  // Reset values
  localparam logic [31:0] MTP_CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] MTP_WIDTH_RST  = 32'h0000_0001;
  localparam logic [31:0] MTP_COUNTS_RST = 32'h0001_0101;

  // Clock and latency
  localparam int MTP_CLK_MHZ      = 40;
  localparam int MTP_US_PER_WIDTH = 1;   // width register unit, microseconds
  localparam int MTP_CYC_PER_UNIT = MTP_US_PER_WIDTH * MTP_CLK_MHZ;
  localparam int MTP_LATENCY_NS   = 1000;
  localparam int MTP_LATENCY_CYC  = MTP_LATENCY_NS * MTP_CLK_MHZ / 1000;

  // Port modes
  typedef enum logic [3:0] {
    MTP_DISABLED  = 4'h0,
    MTP_GP_IN     = 4'h1,
    MTP_IN_REL    = 4'h2,
    MTP_IN_ABS    = 4'h3,
    MTP_IN_HOME   = 4'h4,
    MTP_GP_OUT    = 4'h5,
    MTP_OUT_MOVE  = 4'h6,
    MTP_OUT_MAXV  = 4'h7,
    MTP_STEP_FWD  = 4'h8,
    MTP_STEP_REV  = 4'h9,
    MTP_STEP_BOTH = 4'ha
  } mtp_mode_e;

  // Position step sequencer states
  typedef enum logic [1:0] {
    MTP_SQ_IDLE = 2'b00,
    MTP_SQ_FWD  = 2'b01,
    MTP_SQ_REV  = 2'b10,
    MTP_SQ_DONE = 2'b11
  } mtp_seq_e;

endpackage

// >>> src/mtp_pulse.sv
// Pulse stretcher for the position compare output.
// Assumes a start strobe from logic on pclk and a nonzero width.
`timescale 1ns/10ps
module mtp_pulse (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        start,
  input  wire logic [31:0] width_cyc,
  // Result
  output logic             active
);
  import mtp_pkg::*;

  logic [31:0] cnt_reg;

  // Count down the width; a start during a pulse restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0000_0000;
    end else if (start) begin
      cnt_reg <= width_cyc;
    end else if (cnt_reg != 32'h0000_0000) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
    end
  end

  assign active = (cnt_reg != 32'h0000_0000);

endmodule // mtp_pulse

// >>> src/mtp_trigger_ports.sv
// Two configurable trigger ports with APB configuration and position compare.
// Assumes motion status and a signed 32-bit actual position on pclk.
`timescale 1ns/10ps
module mtp_trigger_ports (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger port one pin
  input  wire logic        trigger_port_one_i,
  output logic             trigger_port_one_o,
  output logic             trigger_port_one_oe,
  // Trigger port two pin
  input  wire logic        trigger_port_two_i,
  output logic             trigger_port_two_o,
  output logic             trigger_port_two_oe,
  // Motion status
  input  wire logic        in_motion,
  input  wire logic        at_max_vel,
  input  wire logic        moving_fwd,
  input  wire logic [31:0] actual_pos,
  // Move requests
  output logic             move_rel_req,
  output logic             move_abs_req,
  output logic             move_home_req,
  output logic [31:0]      move_rel_dist,
  output logic [31:0]      move_abs_pos
);
  import mtp_pkg::*;

  logic [31:0] cfg_reg, gpo_reg, width_reg, counts_reg, rel_reg, abs_reg;
  logic [31:0] start_f_reg, intvl_f_reg, start_r_reg, intvl_r_reg;
  logic [2:0]  sync_reg [2];
  logic [1:0]  in_state_reg;
  logic [1:0]  act_lvl;
  logic [1:0]  edge_act;
  logic [3:0]  mode [2];
  logic [1:0]  pol;
  logic [1:0]  is_step, is_out;
  logic        clash;
  logic        wr_en, rd_en, addr_ok;
  logic        rel_req_reg, abs_req_reg, home_req_reg;
  mtp_seq_e    seq_reg;
  logic [31:0] target_reg;
  logic [7:0]  left_reg, cyc_reg;
  logic        hit, pulse_act;
  logic [1:0]  port_drv;
  logic [31:0] width_cyc;

  function automatic logic [3:0] port_mode(input logic [31:0] c, input int p);
    port_mode = c[p*MTP_CFG_PORT_STRIDE +: 4];
  endfunction

  function automatic logic mode_is_step(input logic [3:0] m);
    mode_is_step = (m == MTP_STEP_FWD) || (m == MTP_STEP_REV) || (m == MTP_STEP_BOTH);
  endfunction

  // Per-port decode of mode and polarity
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      mode[p]    = port_mode(cfg_reg, p);
      pol[p]     = cfg_reg[p*MTP_CFG_PORT_STRIDE + MTP_CFG_POL_BIT];
      is_step[p] = mode_is_step(mode[p]);
      is_out[p]  = (mode[p] >= MTP_GP_OUT) && (mode[p] <= MTP_STEP_BOTH);
    end
  end
  assign clash = is_step[0] & is_step[1];

  // APB decode; zero-wait, error on unmapped offsets
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= MTP_ABS_POS_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & penable & ~pwrite & addr_ok;

  // Register writes; a step mode that would land on a second port is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= MTP_CFG_RST;
      gpo_reg     <= 32'h0000_0000;
      width_reg   <= MTP_WIDTH_RST;
      counts_reg  <= MTP_COUNTS_RST;
      start_f_reg <= 32'h0000_0000;
      intvl_f_reg <= 32'h0000_0000;
      start_r_reg <= 32'h0000_0000;
      intvl_r_reg <= 32'h0000_0000;
      rel_reg     <= 32'h0000_0000;
      abs_reg     <= 32'h0000_0000;
    end else if (wr_en) begin
      case (paddr)
        MTP_CFG_OFS: begin
          if (!(mode_is_step(port_mode(pwdata, 0)) && mode_is_step(port_mode(pwdata, 1)))) begin
            cfg_reg <= pwdata;
          end
        end
        MTP_GPO_OFS:      gpo_reg     <= pwdata;
        MTP_WIDTH_OFS:    width_reg   <= pwdata;
        MTP_START_F_OFS:  start_f_reg <= pwdata;
        MTP_INTVL_F_OFS:  intvl_f_reg <= pwdata;
        MTP_START_R_OFS:  start_r_reg <= pwdata;
        MTP_INTVL_R_OFS:  intvl_r_reg <= pwdata;
        MTP_COUNTS_OFS:   counts_reg  <= pwdata;
        MTP_REL_DIST_OFS: rel_reg     <= pwdata;
        MTP_ABS_POS_OFS:  abs_reg     <= pwdata;
        default: ;
      endcase
    end
  end

  // Read data registered in the setup phase, held for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        MTP_CFG_OFS:      prdata <= cfg_reg;
        MTP_STATUS_OFS:   prdata <= {28'h0000000, (seq_reg != MTP_SQ_IDLE), clash, in_state_reg};
        MTP_GPO_OFS:      prdata <= gpo_reg;
        MTP_WIDTH_OFS:    prdata <= width_reg;
        MTP_START_F_OFS:  prdata <= start_f_reg;
        MTP_INTVL_F_OFS:  prdata <= intvl_f_reg;
        MTP_START_R_OFS:  prdata <= start_r_reg;
        MTP_INTVL_R_OFS:  prdata <= intvl_r_reg;
        MTP_COUNTS_OFS:   prdata <= counts_reg;
        MTP_REL_DIST_OFS: prdata <= rel_reg;
        MTP_ABS_POS_OFS:  prdata <= abs_reg;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Three-stage pin synchronisers; change accepted when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg[0]  <= 3'h7; // Weak pull-up idles high
      sync_reg[1]  <= 3'h7;
      in_state_reg <= 2'b11;
    end else begin
      sync_reg[0] <= {sync_reg[0][1:0], trigger_port_one_i};
      sync_reg[1] <= {sync_reg[1][1:0], trigger_port_two_i};
      for (int p = 0; p < 2; p++) begin
        if (sync_reg[p][1] == sync_reg[p][2]) begin
          in_state_reg[p] <= sync_reg[p][2];
        end
      end
    end
  end

  // Active level after polarity; edge only from inactive to active
  // Previous pin level is kept raw, so a polarity write over a held pin is no edge
  logic [1:0] pin_prev_reg;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      act_lvl[p]  = in_state_reg[p] ~^ pol[p];
      edge_act[p] = act_lvl[p] & ~(pin_prev_reg[p] ~^ pol[p]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 2'b11; // Matches synchroniser reset, no edge out of reset
    end else begin
      pin_prev_reg <= in_state_reg;
    end
  end

  // One-cycle move requests; disabled ports are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_req_reg  <= 1'b0;
      abs_req_reg  <= 1'b0;
      home_req_reg <= 1'b0;
    end else begin
      rel_req_reg  <= (edge_act[0] && mode[0] == MTP_IN_REL) || (edge_act[1] && mode[1] == MTP_IN_REL);
      abs_req_reg  <= (edge_act[0] && mode[0] == MTP_IN_ABS) || (edge_act[1] && mode[1] == MTP_IN_ABS);
      home_req_reg <= (edge_act[0] && mode[0] == MTP_IN_HOME) || (edge_act[1] && mode[1] == MTP_IN_HOME);
    end
  end
  assign move_rel_req  = rel_req_reg;
  assign move_abs_req  = abs_req_reg;
  assign move_home_req = home_req_reg;
  assign move_rel_dist = rel_reg;
  assign move_abs_pos  = abs_reg;

  // Position step sequencer; one compare each cycle keeps latency in one clock
  logic [3:0] step_mode;
  assign step_mode = is_step[0] ? mode[0] : (is_step[1] ? mode[1] : MTP_DISABLED);
  assign hit = ((seq_reg == MTP_SQ_FWD) && moving_fwd && in_motion && ($signed(actual_pos) >= $signed(target_reg)))
            || ((seq_reg == MTP_SQ_REV) && !moving_fwd && in_motion && ($signed(actual_pos) <= $signed(target_reg)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg    <= MTP_SQ_IDLE;
      target_reg <= 32'h0000_0000;
      left_reg   <= 8'h00;
      cyc_reg    <= 8'h00;
    end else if (step_mode == MTP_DISABLED) begin
      seq_reg <= MTP_SQ_IDLE;
    end else begin
      case (seq_reg)
        MTP_SQ_IDLE: begin
          cyc_reg <= counts_reg[MTP_CNT_CYC_LSB +: 8];
          if (step_mode == MTP_STEP_REV) begin
            seq_reg    <= MTP_SQ_REV;
            target_reg <= start_r_reg;
            left_reg   <= counts_reg[MTP_CNT_REV_LSB +: 8];
          end else begin
            seq_reg    <= MTP_SQ_FWD;
            target_reg <= start_f_reg;
            left_reg   <= counts_reg[MTP_CNT_FWD_LSB +: 8];
          end
        end
        MTP_SQ_FWD: begin
          if (hit) begin
            target_reg <= target_reg + intvl_f_reg;
            left_reg   <= left_reg - 8'h01;
          end
          if (left_reg == 8'h00 || (hit && left_reg == 8'h01)) begin
            if (step_mode == MTP_STEP_BOTH) begin
              seq_reg    <= MTP_SQ_REV;
              target_reg <= start_r_reg;
              left_reg   <= counts_reg[MTP_CNT_REV_LSB +: 8];
            end else if (cyc_reg > 8'h01) begin
              cyc_reg    <= cyc_reg - 8'h01;
              target_reg <= start_f_reg;
              left_reg   <= counts_reg[MTP_CNT_FWD_LSB +: 8];
            end else begin
              seq_reg <= MTP_SQ_DONE;
            end
          end
        end
        MTP_SQ_REV: begin
          if (hit) begin
            target_reg <= target_reg - intvl_r_reg;
            left_reg   <= left_reg - 8'h01;
          end
          if (left_reg == 8'h00 || (hit && left_reg == 8'h01)) begin
            if (cyc_reg > 8'h01) begin
              cyc_reg <= cyc_reg - 8'h01;
              if (step_mode == MTP_STEP_BOTH) begin
                seq_reg    <= MTP_SQ_FWD;
                target_reg <= start_f_reg;
                left_reg   <= counts_reg[MTP_CNT_FWD_LSB +: 8];
              end else begin
                target_reg <= start_r_reg;
                left_reg   <= counts_reg[MTP_CNT_REV_LSB +: 8];
              end
            end else begin
              seq_reg <= MTP_SQ_DONE;
            end
          end
        end
        MTP_SQ_DONE: seq_reg <= MTP_SQ_DONE; // Rearmed when neither port is in a step mode
        default:     seq_reg <= MTP_SQ_IDLE;
      endcase
    end
  end

  // Width in clock cycles, at least one
  assign width_cyc = (width_reg == 32'h0000_0000) ? 32'h0000_0001 : width_reg * 32'(MTP_CYC_PER_UNIT);

  mtp_pulse u_pulse (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (hit),
    .width_cyc (width_cyc),
    .active    (pulse_act)
  );

  // Output level selection then polarity; disabled and inputs undriven
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      case (mode[p])
        MTP_GP_OUT:   port_drv[p] = gpo_reg[p] ~^ pol[p];
        MTP_OUT_MOVE: port_drv[p] = in_motion;
        MTP_OUT_MAXV: port_drv[p] = at_max_vel;
        MTP_STEP_FWD, MTP_STEP_REV, MTP_STEP_BOTH: port_drv[p] = pulse_act;
        default:      port_drv[p] = 1'b0;
      endcase
    end
  end
  // GP output holds the raw value; others map active to the polarity level
  assign trigger_port_one_o  = (mode[0] == MTP_GP_OUT) ? gpo_reg[0] : (port_drv[0] ~^ pol[0]);
  assign trigger_port_two_o  = (mode[1] == MTP_GP_OUT) ? gpo_reg[1] : (port_drv[1] ~^ pol[1]);
  assign trigger_port_one_oe = is_out[0];
  assign trigger_port_two_oe = is_out[1];

  // Checks
  chk_edge_once: assert property (@(posedge pclk) disable iff (!presetn)
    rel_req_reg |=> !rel_req_reg) else $error("relative request lasted two cycles");
  chk_edge_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_act[0] && mode[0] == MTP_IN_HOME) |=> home_req_reg) else $error("home edge lost");
  chk_no_both_step: assert property (@(posedge pclk) disable iff (!presetn)
    !clash) else $error("step mode on both ports");
  chk_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[0] == MTP_DISABLED) |-> !trigger_port_one_oe) else $error("disabled port driven");
  chk_motion_level: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[1] == MTP_OUT_MOVE) |-> (trigger_port_two_o == (in_motion ~^ pol[1]))) else $error("motion level wrong");
  chk_maxv_level: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[0] == MTP_OUT_MAXV) |-> (trigger_port_one_o == (at_max_vel ~^ pol[0]))) else $error("max vel level wrong");
  chk_pulse_latency: assert property (@(posedge pclk) disable iff (!presetn)
    hit |=> pulse_act) else $error("compare pulse late");
  chk_gpo_value: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[1] == MTP_GP_OUT) |-> (trigger_port_two_o == gpo_reg[1])) else $error("gp output wrong");
  chk_fwd_step: assert property (@(posedge pclk) disable iff (!presetn)
    (hit && seq_reg == MTP_SQ_FWD && left_reg > 8'h01) |=> (target_reg == $past(target_reg) + intvl_f_reg))
    else $error("forward interval not applied");
  cov_rel_move: cover property (@(posedge pclk) rel_req_reg);
  cov_step_hit: cover property (@(posedge pclk) hit);
  cov_both_rev: cover property (@(posedge pclk) seq_reg == MTP_SQ_REV && step_mode == MTP_STEP_BOTH);
  cov_seq_done: cover property (@(posedge pclk) seq_reg == MTP_SQ_DONE);

endmodule // mtp_trigger_ports

// >>> verif/motion_trigger_ports_tb_top.sv
// Self-checking bench for the trigger port block.
// Assumes a 40 MHz clock and an APB slave with no wait states promised.
`timescale 1ns/10ps
module motion_trigger_ports_tb_top;
  import mtp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        p1_i, p1_o, p1_oe, p2_i, p2_o, p2_oe;
  logic        in_motion, at_max_vel, moving_fwd;
  logic [31:0] actual_pos, rel_dist, abs_pos;
  logic        rel_req, abs_req, home_req;
  logic        d1_en, d1_val, d2_en, d2_val, p1_q;
  int          error_cnt, samples_checked, rel_n, abs_n, home_n, rise_n, hi_n;
  logic [31:0] rd;
  logic        er;

  mtp_trigger_ports DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_port_one_i(p1_i), .trigger_port_one_o(p1_o), .trigger_port_one_oe(p1_oe),
    .trigger_port_two_i(p2_i), .trigger_port_two_o(p2_o), .trigger_port_two_oe(p2_oe),
    .in_motion(in_motion), .at_max_vel(at_max_vel), .moving_fwd(moving_fwd), .actual_pos(actual_pos),
    .move_rel_req(rel_req), .move_abs_req(abs_req), .move_home_req(home_req),
    .move_rel_dist(rel_dist), .move_abs_pos(abs_pos));
  mtp_ext_equip EQ1 (.port_o(p1_o), .port_oe(p1_oe), .drv_en(d1_en), .drv_val(d1_val), .pin(p1_i));
  mtp_ext_equip EQ2 (.port_o(p2_o), .port_oe(p2_oe), .drv_en(d2_en), .drv_val(d2_val), .pin(p2_i));

  // Clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Event counters on requests and port one output pulses
  always @(posedge pclk) begin
    p1_q <= p1_o;
    if (rel_req === 1'b1) rel_n++;
    if (abs_req === 1'b1) abs_n++;
    if (home_req === 1'b1) home_n++;
    if (p1_o === 1'b1 && p1_q === 1'b0) rise_n++;
    if (p1_o === 1'b1) hi_n++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready sampled high with the request held
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic pins(input logic e1, input logic v1, input logic e2, input logic v2);
    @(posedge pclk);
    d1_en <= e1; d1_val <= v1; d2_en <= e2; d2_val <= v2;
    repeat (8) @(posedge pclk);  // Covers the input synchroniser
  endtask

  task automatic t_reset_map;
    apb(1'b0, MTP_CFG_OFS, 32'h0);    chk("cfg_rst", rd, MTP_CFG_RST);
    apb(1'b0, MTP_WIDTH_OFS, 32'h0);  chk("width_rst", rd, MTP_WIDTH_RST);
    apb(1'b0, MTP_COUNTS_OFS, 32'h0); chk("counts_rst", rd, MTP_COUNTS_RST);
    chk("oe_rst", {p1_oe, p2_oe}, 32'h0);
    apb(1'b1, 8'h2c, 32'h5);          chk("unmapped_err", er, 32'h1);
  endtask

  // Edge-only move triggers with both polarities
  task automatic t_move_trig;
    apb(1'b1, MTP_REL_DIST_OFS, 32'h0000_1234);
    apb(1'b1, MTP_ABS_POS_OFS, 32'hffff_ff00);
    pins(1'b1, 1'b1, 1'b0, 1'b0);                        // Port one active before arming
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0312);               // One rel high, two abs low
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk("rel_level_only", rel_n, 0);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (30) @(posedge pclk);                         // Held active level
    chk("rel_once", rel_n, 1);
    chk("rel_dist", rel_dist, 32'h0000_1234);
    pins(1'b1, 1'b0, 1'b0, 1'b0);                        // Back to inactive first
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    chk("rel_again", rel_n, 2);
    chk("abs_fall", abs_n, 1);
    chk("abs_pos", abs_pos, 32'hffff_ff00);
    chk("no_cross", {home_n[7:0], 8'h0}, 32'h0);
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0004);               // Home, port two off
    pins(1'b1, 1'b0, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    chk("home_req", home_n, 1);
    chk("off_ignored", abs_n, 1);
  endtask

  task automatic t_gp_io;
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0101);
    pins(1'b1, 1'b0, 1'b0, 1'b0);                        // Two left to pull-up
    apb(1'b0, MTP_STATUS_OFS, 32'h0);
    chk("gp_in", rd[1:0], 32'h2);
    chk("gp_in_oe", {p1_oe, p2_oe}, 32'h0);
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0505);
    apb(1'b1, MTP_GPO_OFS, 32'h0000_0001);
    @(posedge pclk);                                     // Write lands at the access edge
    chk("gp_out", {p1_oe, p2_oe, p1_o, p2_o}, 32'he);
    apb(1'b1, MTP_GPO_OFS, 32'h0000_0002);
    @(posedge pclk);
    chk("gp_out2", {p1_o, p2_o}, 32'h1);
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0617);               // One maxv high, two motion low
    in_motion <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk("motion_low", {p1_o, p2_o}, 32'h0);
    at_max_vel <= 1'b1;
    in_motion <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk("maxv_high", {p1_o, p2_o}, 32'h3);
    at_max_vel <= 1'b0;
  endtask

  // Forward steps: start 10, interval 5, two pulses of 1 us
  task automatic t_steps;
    int r0, h0, lat;
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0000);
    apb(1'b1, MTP_START_F_OFS, 32'd10);
    apb(1'b1, MTP_INTVL_F_OFS, 32'd5);
    apb(1'b1, MTP_COUNTS_OFS, 32'h0001_0102);
    apb(1'b1, MTP_WIDTH_OFS, 32'd1);
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0018);
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0918);               // Second step port refused
    apb(1'b0, MTP_CFG_OFS, 32'h0);
    chk("step_one_port", rd, 32'h0000_0018);
    r0 = rise_n;
    h0 = hi_n;
    in_motion <= 1'b1; moving_fwd <= 1'b1;
    for (int p = 0; p <= 20; p++) begin
      actual_pos <= p;
      lat = 0;
      repeat (60) begin
        @(posedge pclk);
        if (p == 10 && rise_n == r0) lat++;
      end
      if (p == 10) chk("match_latency", lat <= MTP_LATENCY_CYC, 32'h1);
    end
    chk("step_pulses", rise_n - r0, 32'd2);
    chk("pulse_width", hi_n - h0, 2 * MTP_CYC_PER_UNIT);
    in_motion <= 1'b0;
  endtask

  // Both directions, two move cycles: fwd 10 and 15, rev 12, per cycle
  task automatic t_steps_both;
    int r0, h0;
    apb(1'b1, MTP_CFG_OFS, 32'h0000_0000);               // Rearm the sequencer
    apb(1'b1, MTP_START_R_OFS, 32'd12);
    apb(1'b1, MTP_INTVL_R_OFS, 32'd4);
    apb(1'b1, MTP_COUNTS_OFS, 32'h0002_0102);
    apb(1'b1, MTP_CFG_OFS, 32'h0000_001a);
    @(posedge pclk);
    r0 = rise_n;
    h0 = hi_n;
    in_motion <= 1'b1;
    repeat (2) begin
      moving_fwd <= 1'b1;
      for (int p = 0; p <= 20; p++) begin
        actual_pos <= p;
        repeat (20) @(posedge pclk);
      end
      moving_fwd <= 1'b0;
      for (int p = 20; p >= 0; p--) begin
        actual_pos <= p;
        repeat (20) @(posedge pclk);
      end
    end
    in_motion <= 1'b0;
    chk("both_pulses", rise_n - r0, 32'd6);
    chk("both_width", hi_n - h0, 6 * MTP_CYC_PER_UNIT);
  endtask

  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(25 * 20000);
    error_cnt++;
    final_report();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    in_motion = 1'b0; at_max_vel = 1'b0; moving_fwd = 1'b0; actual_pos = 32'h0;
    d1_en = 1'b1; d1_val = 1'b0; d2_en = 1'b0; d2_val = 1'b0; p1_q = 1'b0;
    error_cnt = 0; samples_checked = 0; rel_n = 0; abs_n = 0; home_n = 0; rise_n = 0; hi_n = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_move_trig();
    t_gp_io();
    t_steps();
    t_steps_both();
    final_report();
  end
endmodule // motion_trigger_ports_tb_top

// >>> verif/mtp_ext_equip.sv
// Outside equipment model on one trigger port pin.
// Assumes the bench selects when it drives and at what level.
`timescale 1ns/10ps
module mtp_ext_equip (
  // Device side of the pin
  input  wire logic port_o,
  input  wire logic port_oe,
  // Equipment drive control
  input  wire logic drv_en,
  input  wire logic drv_val,
  // Resolved pin level
  output logic      pin
);
  // Device drive wins; an undriven pin floats high through the weak pull-up
  always_comb begin
    if (port_oe)
      pin = port_o;
    else if (drv_en)
      pin = drv_val;
    else
      pin = 1'b1;
  end
endmodule // mtp_ext_equip
